/* shared/stop_ctrl_pkg.sv */
package stop_ctrl_pkg;
	localparam int NUM_OUTS = 8;
	localparam logic [7:0] STOPPABLE_RST = 8'h00;
	localparam int CLK_PERIOD_NS = 10;
	localparam int STABLE_EDGES = 2;
	localparam logic [1:0] STABLE_CNT_MAX = 2'(STABLE_EDGES - 1);
	localparam int RESTART_LAT = 2;
	localparam logic [2:0] RESTART_CNT = 3'(RESTART_LAT);
	localparam int REDRIVE_NS = 10;
	localparam int REDRIVE_CYC = (REDRIVE_NS / CLK_PERIOD_NS < 1) ? 1 : REDRIVE_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic [NUM_OUTS-1:0] true_val;
		logic [NUM_OUTS-1:0] true_oe;
		logic [NUM_OUTS-1:0] comp_val;
		logic [NUM_OUTS-1:0] comp_oe;
	} diff_pins_t;
endpackage

/* src/halt_filter.sv */
`timescale 1ns/1ns
module halt_filter
	import stop_ctrl_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic edge_en_i,
	input wire logic raw_n_i,
	output logic halt_n_o
);
	logic sync1_q, sync2_q, sync1_d, sync2_d;
	logic halt_n_q, halt_n_d;
	logic [1:0] cnt_q, cnt_d;

	always_comb
	begin
		sync1_d = raw_n_i;
		sync2_d = sync1_q;
		halt_n_d = halt_n_q;
		cnt_d = cnt_q;
		if (edge_en_i)
		begin
			if (sync2_q == halt_n_q)
				cnt_d = 2'h0;
			else if (cnt_q == STABLE_CNT_MAX)
			begin
				halt_n_d = sync2_q;
				cnt_d = 2'h0;
			end
			else
				cnt_d = cnt_q + 2'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			halt_n_q <= 1'b1;
			cnt_q <= 2'h0;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			halt_n_q <= halt_n_d;
			cnt_q <= cnt_d;
		end
	end

	assign halt_n_o = halt_n_q;
endmodule

/* src/diff_output_stop_control.sv */
`timescale 1ns/1ns
// Summary of operation
// - stoppable outputs halt after their next rising transition; free-running ones keep toggling
// - drive mode 0: true leg driven high, complement leg undriven
// - drive mode 1: both legs of stopped pairs undriven
// - release restarts stopped outputs cleanly, no runt pulses
// - restart comes eleven to twelve reference clock cycles (five and a half to six output periods) after release
// - all stopped outputs restart on the same cycle
// - tri-state mode: true legs driven high six to seven reference clock cycles after release
// - stop input level accepted after two stable complement rising edges
// - per-output stoppable bit, 1 stoppable, all reset to 0
module diff_output_stop_control
	import stop_ctrl_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic output_halt_n_i,
	input wire logic drive_mode_i,
	input wire logic cfg_we_i,
	input wire logic [NUM_OUTS-1:0] cfg_stoppable_i,
	output logic [NUM_OUTS-1:0] stoppable_o,
	output logic [NUM_OUTS-1:0] stopped_o,
	output logic [NUM_OUTS-1:0] diff_out_true_o,
	output logic [NUM_OUTS-1:0] diff_out_true_oe_o,
	output logic [NUM_OUTS-1:0] diff_out_comp_o,
	output logic [NUM_OUTS-1:0] diff_out_comp_oe_o
);
	typedef enum logic [1:0] {RUN, STOPPING, HALTED, RESUMING} stop_state_t;

	// reference clock, divided by two, is the output clock
	logic phase_q, phase_d;
	logic [NUM_OUTS-1:0] stoppable_q, stoppable_d;
	logic [NUM_OUTS-1:0] stop_set_q, stop_set_d;
	stop_state_t state_q, state_d;
	logic [2:0] lat_q, lat_d;
	diff_pins_t pins_q, pins_d;
	logic halt_n, comp_rise;

	// complement output rises when the true phase falls
	assign comp_rise = phase_q;

	halt_filter halt_filter_i (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.edge_en_i(comp_rise),
		.raw_n_i(output_halt_n_i),
		.halt_n_o(halt_n)
	);

	// output clock phase
	always_comb
	begin
		phase_d = ~phase_q;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			phase_q <= 1'b0;
		else
			phase_q <= phase_d;
	end

	// per-output stoppable bits
	always_comb
	begin
		stoppable_d = cfg_we_i ? cfg_stoppable_i : stoppable_q;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			stoppable_q <= STOPPABLE_RST;
		else
			stoppable_q <= stoppable_d;
	end

	// stop and restart sequencing
	always_comb
	begin
		state_d = state_q;
		stop_set_d = stop_set_q;
		lat_d = lat_q;
		case (state_q)
			RUN:
				if (!halt_n)
					state_d = STOPPING;
			STOPPING:
				// freeze after the next rising transition, true leg high in drive mode 0
				if (!phase_q)
				begin
					stop_set_d = stoppable_q;
					state_d = HALTED;
				end
			HALTED:
				if (halt_n)
				begin
					lat_d = RESTART_CNT;
					state_d = RESUMING;
				end
			RESUMING:
				// restart only at a period boundary, all together
				if (lat_q != 3'h0)
				begin
					if (phase_q)
						lat_d = lat_q - 3'h1;
				end
				else if (phase_q)
				begin
					stop_set_d = '0;
					state_d = RUN;
				end
			default:
				state_d = RUN;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			stop_set_q <= '0;
			state_q <= RUN;
			lat_q <= 3'h0;
		end
		else
		begin
			stop_set_q <= stop_set_d;
			state_q <= state_d;
			lat_q <= lat_d;
		end
	end

	// pin drive per output pair
	always_comb
	begin
		for (int i = 0; i < NUM_OUTS; i++)
		begin
			if (stop_set_d[i])
			begin
				pins_d.true_val[i] = ~drive_mode_i;
				pins_d.true_oe[i] = ~drive_mode_i;
				pins_d.comp_val[i] = 1'b0;
				pins_d.comp_oe[i] = 1'b0;
			end
			else
			begin
				pins_d.true_val[i] = phase_d;
				pins_d.true_oe[i] = 1'b1;
				pins_d.comp_val[i] = ~phase_d;
				pins_d.comp_oe[i] = 1'b1;
			end
			// tri-state mode: re-drive high from when the filtered release moves the state to RESUMING
			if (state_d == RESUMING && stop_set_d[i])
			begin
				pins_d.true_val[i] = 1'b1;
				pins_d.true_oe[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			pins_q <= '0;
		else
			pins_q <= pins_d;
	end

	assign stoppable_o = stoppable_q;
	assign stopped_o = stop_set_q;
	assign diff_out_true_o = pins_q.true_val;
	assign diff_out_true_oe_o = pins_q.true_oe;
	assign diff_out_comp_o = pins_q.comp_val;
	assign diff_out_comp_oe_o = pins_q.comp_oe;
endmodule

/* test/halt_ctrl_model.sv */
`timescale 1ns/1ns
module halt_ctrl_model (
	input wire logic sys_clk_i,
	input wire logic halt_req_i,
	input wire logic blip_i,
	output logic output_halt_n_o = 1'b1
);
	// stop level only moves while the reference clock runs
	always @(posedge sys_clk_i)
		output_halt_n_o <= !(halt_req_i || blip_i);
endmodule

/* test/diff_output_stop_control_chk.sv */
`timescale 1ns/1ns
module diff_output_stop_control_chk (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic output_halt_n_i,
	input wire logic drive_mode_i,
	input wire logic [7:0] stoppable_o,
	input wire logic [7:0] stopped_o,
	input wire logic [7:0] diff_out_true_o,
	input wire logic [7:0] diff_out_true_oe_o,
	input wire logic [7:0] diff_out_comp_oe_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	wire [7:0] pk = diff_out_true_o & diff_out_true_oe_o & ~diff_out_comp_oe_o;
	wire [7:0] so = stopped_o;
	sequence held_low; $fell(output_halt_n_i) ##1 !output_halt_n_i [*8]; endsequence
	halt_takes_a: assert property (held_low |-> ##[0:6] so == stoppable_o)
		else $error("no stop");
	free_kept_a: assert property ((so & ~stoppable_o) == 0)
		else $error("free stopped");
	park_high_a: assert property (!drive_mode_i && $stable(drive_mode_i)
		|-> (pk & so) == so) else $error("bad park");
	tri_stop_a: assert property (drive_mode_i && $stable(drive_mode_i)
		&& !output_halt_n_i |-> ((diff_out_true_oe_o | diff_out_comp_oe_o) & so) == 0)
		else $error("driven");
	high_redrive_a: assert property (drive_mode_i && $rose(output_halt_n_i) && |so
		|-> ##[1:8] (pk & stoppable_o) == stoppable_o) else $error("no redrive");
	restart_win_a: assert property ($rose(output_halt_n_i) && |so
		|-> (|so) [*4] ##[1:9] so == 0) else $error("restart out of window");
	restart_all_a: assert property (|$past(so) && so != $past(so) |-> so == 0)
		else $error("split restart");
	glitch_drop_a: assert property ($rose(output_halt_n_i) && $past(output_halt_n_i, 2)
		&& so == 0 |-> ##1 so == 0 [*8]) else $error("glitch taken");
endmodule
bind diff_output_stop_control diff_output_stop_control_chk chk_i (.sys_clk_i, .nrst_i,
	.output_halt_n_i, .drive_mode_i, .stoppable_o, .stopped_o, .diff_out_true_o,
	.diff_out_true_oe_o, .diff_out_comp_oe_o);

/* test/diff_output_stop_control_tb.sv */
`timescale 1ns/1ns
module diff_output_stop_control_tb;
	logic clk = 1'b0, rst_n = 1'b0, mode = 1'b0, we = 1'b0, req = 1'b0, blip = 1'b0, hn;
	logic [7:0] cfg = 8'h00, stb, stp, tv, toe, cv, coe;
	int fails = 0, cmp_count = 0;
	always #5 clk = ~clk;
	halt_ctrl_model halt_ctrl_model_i (.sys_clk_i(clk), .halt_req_i(req), .blip_i(blip),
		.output_halt_n_o(hn));
	diff_output_stop_control diff_output_stop_control_i (.sys_clk_i(clk), .nrst_i(rst_n),
		.output_halt_n_i(hn), .drive_mode_i(mode), .cfg_we_i(we), .cfg_stoppable_i(cfg),
		.stoppable_o(stb), .stopped_o(stp), .diff_out_true_o(tv), .diff_out_true_oe_o(toe),
		.diff_out_comp_o(cv), .diff_out_comp_oe_o(coe));
	task chk(string what, logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s exp %h got %h", what, exp, got);
		end
	endtask
	task close_out;
		if (fails == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task stop_episode(logic m);
		logic [7:0] t0;
		int n;
		mode = m;
		req = 1'b1;
		repeat (16) @(negedge clk);
		chk("stopped", stp, 8'h5a);
		chk("true_oe", toe & 8'h5a, m ? 8'h00 : 8'h5a);
		chk("true_park", tv & 8'h5a, m ? 8'h00 : 8'h5a);
		chk("comp_oe", coe & 8'h5a, 8'h00);
		chk("comp_park", cv & 8'h5a, 8'h00);
		chk("pair", (cv ^ tv) & 8'ha5, 8'ha5);
		t0 = tv;
		@(negedge clk);
		chk("free", (tv ^ t0) & 8'ha5, 8'ha5);
		req = 1'b0;
		n = 0;
		while (stp != 8'h00 && n < 24)
		begin
			@(negedge clk);
			n++;
		end
		chk("restart", stp, 8'h00);
		chk("latency", 8'(n >= 5 && n <= 13), 8'h01);
	endtask
	task glitch_ignore;
		blip = 1'b1;
		@(negedge clk);
		blip = 1'b0;
		repeat (12)
		begin
			@(negedge clk);
			chk("glitch", stp, 8'h00);
		end
	endtask
	initial
	begin
		repeat (8) @(negedge clk);
		chk("rst_stb", stb, 8'h00);
		rst_n = 1'b1;
		@(negedge clk);
		cfg = 8'h5a;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
		@(negedge clk);
		chk("stb", stb, 8'h5a);
		stop_episode(1'b0);
		stop_episode(1'b1);
		glitch_ignore;
		close_out;
	end
	initial
	begin
		#20000;
		fails++;
		close_out;
	end
endmodule
